// [logic/ahcr_pkg.sv]
package ahcr_pkg;

  // ----------------------------------------------------------------------
  // Register indices on the module bus (16-bit words).
  // ----------------------------------------------------------------------
  localparam logic [2:0] IDX_LEVELS = 3'h0;
  localparam logic [2:0] IDX_PORTS  = 3'h1;
  localparam logic [2:0] IDX_DIRS   = 3'h2;
  localparam logic [2:0] IDX_SETUP  = 3'h3;

  // ----------------------------------------------------------------------
  // Field positions. Bit 0 of the printed layout is the word's MSB.
  // ----------------------------------------------------------------------
  localparam int LVL1_MSB   = 15;
  localparam int LVL1_LSB   = 11;
  localparam int LVL2_MSB   = 10;
  localparam int LVL2_LSB   = 6;
  localparam int SETUP_EXP  = 15;
  localparam int SETUP_SWAP = 12;
  localparam int PRE_MSB    = 6;
  localparam int PRE_LSB    = 0;
  localparam int PORTA_MSB  = 15;
  localparam int PORTA_LSB  = 8;

  // ----------------------------------------------------------------------
  // Writable masks and values after reset.
  // ----------------------------------------------------------------------
  localparam logic [15:0] LVL_MASK    = 16'hFFC0;
  localparam logic [15:0] SETUP_MASK  = 16'h907F;
  localparam logic [15:0] LVL_RESET   = 16'h0000;
  localparam logic [15:0] SETUP_RESET = 16'h0000;
  localparam logic [7:0]  DIR_RESET   = 8'h00;

  // ----------------------------------------------------------------------
  // Prescaler limits: the smallest divisor is two system clocks.
  // ----------------------------------------------------------------------
  localparam logic [6:0] PRE_MIN_LIMIT = 7'h01;

endpackage : ahcr_pkg

// [logic/ahcr_prescaler.sv]
`timescale 1ns/1ps

module ahcr_prescaler
  import ahcr_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Divisor code and conversion clock enable.
  input  wire logic [6:0] prescaler,
  output logic            tick
);

  // ----------------------------------------------------------------------
  // Period counter.
  // ----------------------------------------------------------------------
  logic [6:0] cnt_r;
  logic [6:0] lim_r;
  logic       tick_r;
  wire        period_end = (cnt_r == lim_r);
  // Codes 0 and 1 both give a limit of 1, so the divisor never drops under 2.
  wire  [6:0] lim_nxt    = (prescaler < 7'h02) ? PRE_MIN_LIMIT : prescaler;
  wire  [6:0] cnt_nxt    = period_end ? 7'h00 : cnt_r + 7'h01;

  // The limit is sampled only at a period end, so a new code never cuts a
  // period short and takes effect from the next one.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r  <= 7'h00;
      lim_r  <= PRE_MIN_LIMIT;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= period_end;
      if (period_end) begin
        lim_r <= lim_nxt;
      end
    end
  end

  assign tick = tick_r;

  // ----------------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------------
  AST_TICK_SPACING: assert property (@(posedge clk) disable iff (!rst_n)
    tick_r |=> !tick_r) else $error("conversion tick closer than two clocks");
  AST_LIMIT_FLOOR: assert property (@(posedge clk) disable iff (!rst_n)
    lim_r >= PRE_MIN_LIMIT) else $error("prescaler limit below minimum");
  AST_PERIOD_LEN: assert property (@(posedge clk) disable iff (!rst_n)
    (tick_r && lim_r == 7'h03) |=> (!tick_r) [*3] ##1 tick_r)
    else $error("divide-by-4 period wrong");

endmodule : ahcr_prescaler

// [logic/ahcr_top.sv]
`timescale 1ns/1ps

// Overview of operation
// - Two 5-bit request level fields, queue one high, queue two next.
// - Level register reachable only by supervisor data accesses.
// - Reserved bits of level and setup registers read zero, ignore writes.
// - A pending enabled request drives its level onto the 8-line request bus.
// - Slot select picks one of four slots of eight levels each.
// - Two 8-bit port data registers, each bit input or output.
// - Port read returns pin level for inputs, stored data for outputs.
// - Port data registers are not touched by reset.
// - Direction bit one makes the pin an output, zero an input.
// - Expansion mode forces port A bits 2..0 out with channel select.
// - Expansion mode reads port A bits 2..0 from channel select latches.
// - Setup bit selects internal 40 or external 65 channel multiplexing.
// - Setup swap bit exchanges trigger routing between the two queues.
// - Conversion clock divides system clock by prescaler plus one.
// - Divisor spans 2 to 128; codes zero and one both divide by 2.
// - Each queue's request carries its own programmed level.
module ahcr_top
  import ahcr_pkg::*;
#(
  parameter int PORT_W = 8
) (
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              arst_n,
  // Module bus slave.
  input  wire logic              bus_sel,
  input  wire logic              bus_wr,
  input  wire logic              bus_supervisor,
  input  wire logic [2:0]        bus_idx,
  input  wire logic [1:0]        bus_byte_en,
  input  wire logic [15:0]       bus_wdata,
  output logic [15:0]            bus_rdata,
  output logic                   bus_ack,
  output logic                   bus_err,
  // Interrupt request bus.
  input  wire logic              first_queue_request,
  input  wire logic              second_queue_request,
  input  wire logic [1:0]        level_slot_select,
  output logic [7:0]             irq_lines,
  // Digital ports.
  input  wire logic [PORT_W-1:0] port_a_pins_in,
  output logic [PORT_W-1:0]      port_a_pins_out,
  output logic [PORT_W-1:0]      port_a_pins_oe,
  input  wire logic [PORT_W-1:0] port_b_pins_in,
  output logic [PORT_W-1:0]      port_b_pins_out,
  output logic [PORT_W-1:0]      port_b_pins_oe,
  // Converter side.
  input  wire logic [2:0]        channel_select_addr,
  input  wire logic [2:1]        external_trigger_inputs,
  output logic                   queue1_trigger,
  output logic                   queue2_trigger,
  output logic                   external_channel_expansion,
  output logic                   conversion_clock
);

  // ----------------------------------------------------------------------
  // Reset release.
  // ----------------------------------------------------------------------
  logic rst_meta_r;
  logic rst_n;

  // The release is retimed so that no flop leaves reset on a ragged edge.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  // ----------------------------------------------------------------------
  // Register state.
  // ----------------------------------------------------------------------
  logic [15:0]       lvl_r;
  logic [15:0]       setup_r;
  logic [PORT_W-1:0] dir_a_r;
  logic [PORT_W-1:0] dir_b_r;
  logic [PORT_W-1:0] data_a_r;
  logic [PORT_W-1:0] data_b_r;
  logic [2:0]        chan_sel_r;

  // ----------------------------------------------------------------------
  // Address decode and access checks.
  // ----------------------------------------------------------------------
  wire hit_lvl   = bus_sel && (bus_idx == IDX_LEVELS);
  wire hit_ports = bus_sel && (bus_idx == IDX_PORTS);
  wire hit_dirs  = bus_sel && (bus_idx == IDX_DIRS);
  wire hit_setup = bus_sel && (bus_idx == IDX_SETUP);
  wire mapped    = hit_lvl || hit_ports || hit_dirs || hit_setup;
  // The level register lives in supervisor-only space.
  wire priv_fail = hit_lvl && !bus_supervisor;
  wire acc_err   = bus_sel && (!mapped || priv_fail);
  wire acc_ok    = bus_sel && !acc_err;
  wire wr_ok     = acc_ok && bus_wr;
  wire we_hi     = wr_ok && bus_byte_en[1];
  wire we_lo     = wr_ok && bus_byte_en[0];
  wire [15:0] lane_mask = {{8{bus_byte_en[1]}}, {8{bus_byte_en[0]}}};

  // ----------------------------------------------------------------------
  // Field views.
  // ----------------------------------------------------------------------
  wire [4:0]  first_queue_request_level       = lvl_r[LVL1_MSB:LVL1_LSB];
  wire [4:0]  second_queue_request_level       = lvl_r[LVL2_MSB:LVL2_LSB];
  wire        expand     = setup_r[SETUP_EXP];
  wire        trig_swap  = setup_r[SETUP_SWAP];
  wire [6:0]  prescale   = setup_r[PRE_MSB:PRE_LSB];
  // Only implemented bits can ever be stored in the two control words.
  wire [15:0] lvl_nxt    = (lvl_r & ~(LVL_MASK & lane_mask))
                         | (bus_wdata & LVL_MASK & lane_mask);
  wire [15:0] setup_nxt  = (setup_r & ~(SETUP_MASK & lane_mask))
                         | (bus_wdata & SETUP_MASK & lane_mask);

  // ----------------------------------------------------------------------
  // Port pin steering.
  // ----------------------------------------------------------------------
  wire [PORT_W-1:0] mux_keep  = {{(PORT_W-3){1'b1}}, 3'h0};
  wire [PORT_W-1:0] mux_force = {{(PORT_W-3){1'b0}}, 3'h7};
  wire [PORT_W-1:0] chan_ext  = {{(PORT_W-3){1'b0}}, chan_sel_r};
  // Expansion mode takes the low three pins away from the direction bits.
  wire [PORT_W-1:0] oe_a_nxt  = expand ? ((dir_a_r & mux_keep) | mux_force)
                                       : dir_a_r;
  wire [PORT_W-1:0] out_a_nxt = expand ? ((data_a_r & mux_keep) | chan_ext)
                                       : data_a_r;
  // Reads show the pin for inputs and the stored bit for outputs.
  wire [PORT_W-1:0] rd_a_raw  = (dir_a_r & data_a_r) | (~dir_a_r & port_a_pins_in);
  wire [PORT_W-1:0] port_a_rd = expand ? ((rd_a_raw & mux_keep) | chan_ext)
                                       : rd_a_raw;
  wire [PORT_W-1:0] port_b_rd = (dir_b_r & data_b_r) | (~dir_b_r & port_b_pins_in);

  // ----------------------------------------------------------------------
  // Read data selection.
  // ----------------------------------------------------------------------
  wire [15:0] rd_lvl = lvl_r & LVL_MASK;
  wire [15:0] rd_set = setup_r & SETUP_MASK;
  wire [15:0] rd_mux = hit_lvl   ? rd_lvl
                     : hit_ports ? {port_a_rd, port_b_rd}
                     : hit_dirs  ? {dir_a_r, dir_b_r}
                     : hit_setup ? rd_set
                     : 16'h0000;
  wire [15:0] rdata_nxt = (acc_ok && !bus_wr) ? rd_mux : 16'h0000;

  // ----------------------------------------------------------------------
  // Interrupt level encoding.
  // ----------------------------------------------------------------------
  // Each queue drives one line, only in the slot that holds its level.
  wire [7:0] q1_hit  = (first_queue_request && (first_queue_request_level[4:3] == level_slot_select))
                     ? (8'h01 << first_queue_request_level[2:0]) : 8'h00;
  wire [7:0] q2_hit  = (second_queue_request && (second_queue_request_level[4:3] == level_slot_select))
                     ? (8'h01 << second_queue_request_level[2:0]) : 8'h00;
  // Equal levels simply merge onto one line; software sorts them out.
  wire [7:0] irq_nxt = q1_hit | q2_hit;

  // ----------------------------------------------------------------------
  // Trigger routing.
  // ----------------------------------------------------------------------
  wire q1_trig_nxt = trig_swap ? external_trigger_inputs[2]
                               : external_trigger_inputs[1];
  wire q2_trig_nxt = trig_swap ? external_trigger_inputs[1]
                               : external_trigger_inputs[2];

  // ----------------------------------------------------------------------
  // Control registers with reset.
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lvl_r   <= LVL_RESET;
      setup_r <= SETUP_RESET;
      dir_a_r <= DIR_RESET;
      dir_b_r <= DIR_RESET;
    end else begin
      if (wr_ok && hit_lvl) begin
        lvl_r <= lvl_nxt;
      end
      if (wr_ok && hit_setup) begin
        setup_r <= setup_nxt;
      end
      if (we_hi && hit_dirs) begin
        dir_a_r <= bus_wdata[PORTA_MSB:PORTA_LSB];
      end
      if (we_lo && hit_dirs) begin
        dir_b_r <= bus_wdata[PORT_W-1:0];
      end
    end
  end

  // Port data has no reset on purpose, so its value after power-up is
  // whatever the flops wake with until software writes it.
  always_ff @(posedge clk) begin
    if (we_hi && hit_ports) begin
      data_a_r <= bus_wdata[PORTA_MSB:PORTA_LSB];
    end
    if (we_lo && hit_ports) begin
      data_b_r <= bus_wdata[PORT_W-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Output flops.
  // ----------------------------------------------------------------------
  logic [15:0]       rdata_r;
  logic              ack_r;
  logic              err_r;
  logic [7:0]        irq_r;
  logic [PORT_W-1:0] out_a_r;
  logic [PORT_W-1:0] oe_a_r;
  logic [PORT_W-1:0] out_b_r;
  logic [PORT_W-1:0] oe_b_r;
  logic              q1_trig_r;
  logic              q2_trig_r;
  logic              expand_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r    <= 16'h0000;
      ack_r      <= 1'b0;
      err_r      <= 1'b0;
      irq_r      <= 8'h00;
      chan_sel_r <= 3'h0;
      out_a_r    <= '0;
      oe_a_r     <= '0;
      out_b_r    <= '0;
      oe_b_r     <= '0;
      q1_trig_r  <= 1'b0;
      q2_trig_r  <= 1'b0;
      expand_r   <= 1'b0;
    end else begin
      rdata_r    <= rdata_nxt;
      ack_r      <= acc_ok;
      err_r      <= acc_err;
      irq_r      <= irq_nxt;
      chan_sel_r <= channel_select_addr;
      out_a_r    <= out_a_nxt;
      oe_a_r     <= oe_a_nxt;
      out_b_r    <= data_b_r;
      oe_b_r     <= dir_b_r;
      q1_trig_r  <= q1_trig_nxt;
      q2_trig_r  <= q2_trig_nxt;
      expand_r   <= expand;
    end
  end

  // ----------------------------------------------------------------------
  // Conversion clock divider.
  // ----------------------------------------------------------------------
  ahcr_prescaler u_prescaler (
    .clk       (clk),
    .rst_n     (rst_n),
    .prescaler (prescale),
    .tick      (conversion_clock)
  );

  assign bus_rdata                  = rdata_r;
  assign bus_ack                    = ack_r;
  assign bus_err                    = err_r;
  assign irq_lines                  = irq_r;
  assign port_a_pins_out            = out_a_r;
  assign port_a_pins_oe             = oe_a_r;
  assign port_b_pins_out            = out_b_r;
  assign port_b_pins_oe             = oe_b_r;
  assign queue1_trigger             = q1_trig_r;
  assign queue2_trigger             = q2_trig_r;
  assign external_channel_expansion = expand_r;

  // ----------------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------------
  AST_USER_LEVEL_DENIED: assert property (@(posedge clk) disable iff (!rst_n)
    (hit_lvl && !bus_supervisor) |=> (err_r && !ack_r && $stable(lvl_r)))
    else $error("user access reached the level register");
  AST_RESERVED_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
    ((lvl_r & ~LVL_MASK) == 16'h0000) && ((setup_r & ~SETUP_MASK) == 16'h0000))
    else $error("reserved bit stored");
  AST_Q1_LINE: assert property (@(posedge clk) disable iff (!rst_n)
    (first_queue_request && first_queue_request_level[4:3] == level_slot_select) |=> irq_r[$past(first_queue_request_level[2:0])])
    else $error("queue one level not driven");
  AST_WRONG_SLOT_QUIET: assert property (@(posedge clk) disable iff (!rst_n)
    (first_queue_request_level[4:3] != level_slot_select && second_queue_request_level[4:3] != level_slot_select) |=> irq_r == 8'h00)
    else $error("request driven outside its slot");
  AST_Q2_OWN_LEVEL: assert property (@(posedge clk) disable iff (!rst_n)
    (second_queue_request && !first_queue_request && second_queue_request_level[4:3] == level_slot_select)
    |=> irq_r == (8'h01 << $past(second_queue_request_level[2:0])))
    else $error("queue two level wrong");
  AST_PORT_B_READ: assert property (@(posedge clk) disable iff (!rst_n)
    (hit_ports && acc_ok && !bus_wr) |=> bus_rdata[7:0] == $past(port_b_rd))
    else $error("port B read value wrong");
  AST_DIR_DRIVES_OE: assert property (@(posedge clk) disable iff (!rst_n)
    !expand |=> oe_a_r == $past(dir_a_r) && oe_b_r == $past(dir_b_r))
    else $error("pin enable does not follow direction");
  AST_EXPAND_FORCE: assert property (@(posedge clk) disable iff (!rst_n)
    expand |=> oe_a_r[2:0] == 3'h7 && out_a_r[2:0] == $past(chan_sel_r))
    else $error("channel select pins not forced");
  AST_EXPAND_READ: assert property (@(posedge clk) disable iff (!rst_n)
    (expand && hit_ports && acc_ok && !bus_wr) |=> bus_rdata[10:8] == $past(chan_sel_r))
    else $error("channel select latch not read back");
  AST_TRIGGER_ROUTE: assert property (@(posedge clk) disable iff (!rst_n)
    trig_swap |=> q1_trig_r == $past(external_trigger_inputs[2]))
    else $error("trigger routing not swapped");

endmodule : ahcr_top

// [bench/ahcr_bus_master.sv]
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Processor-side bus master model.
// ----------------------------------------------------------------------
module ahcr_bus_master (
  // Clock.
  input  wire logic        clk,
  // Answer from the register block.
  input  wire logic [15:0] bus_rdata,
  input  wire logic        bus_ack,
  input  wire logic        bus_err,
  // Request to the register block.
  output logic             bus_sel,
  output logic             bus_wr,
  output logic             bus_supervisor,
  output logic [2:0]       bus_idx,
  output logic [1:0]       bus_byte_en,
  output logic [15:0]      bus_wdata
);
  // Idle values at time zero.
  initial begin
    bus_sel        = 1'h0;
    bus_wr         = 1'h0;
    bus_supervisor = 1'h0;
    bus_idx        = 3'h0;
    bus_byte_en    = 2'h0;
    bus_wdata      = 16'h0000;
  end

  // One access per cycle of select. The answer is picked up half a cycle
  // after the taking edge, where the registered reply has settled.
  // Released data is inverted so a stale word is never mistaken for a live one.
  task automatic access(input logic w, input logic s, input logic [2:0] i,
                        input logic [1:0] be, input logic [15:0] wd,
                        output logic [15:0] rd, output logic [1:0] resp);
    @(negedge clk);
    bus_sel        = 1'h1;
    bus_wr         = w;
    bus_supervisor = s;
    bus_idx        = i;
    bus_byte_en    = be;
    bus_wdata      = wd;
    @(negedge clk);
    rd        = bus_rdata;
    resp      = {bus_err, bus_ack};
    bus_sel   = 1'h0;
    bus_wdata = ~wd;
  endtask : access
endmodule : ahcr_bus_master

// [bench/ahcr_top_test.sv]
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Self-checking bench of the converter host register block.
// ----------------------------------------------------------------------
module ahcr_top_test;
  import ahcr_pkg::*;
  localparam logic [1:0] OK = 2'h1;
  localparam logic [1:0] BAD = 2'h2;
  logic clk, arst_n, bus_sel, bus_wr, bus_supervisor, bus_ack, bus_err;
  logic first_queue_request, second_queue_request, queue1_trigger, queue2_trigger;
  logic external_channel_expansion, conversion_clock;
  logic [2:0] bus_idx, channel_select_addr;
  logic [1:0] bus_byte_en, level_slot_select, external_trigger_inputs;
  logic [15:0] bus_wdata, bus_rdata;
  logic [7:0] irq_lines, port_a_pins_in, port_a_pins_out, port_a_pins_oe;
  logic [7:0] port_b_pins_in, port_b_pins_out, port_b_pins_oe;
  int n_fail = 0;
  int n_checks = 0;

  ahcr_top uut (.clk, .arst_n, .bus_sel, .bus_wr, .bus_supervisor, .bus_idx,
    .bus_byte_en, .bus_wdata, .bus_rdata, .bus_ack, .bus_err, .first_queue_request,
    .second_queue_request, .level_slot_select, .irq_lines, .port_a_pins_in,
    .port_a_pins_out, .port_a_pins_oe, .port_b_pins_in, .port_b_pins_out,
    .port_b_pins_oe, .channel_select_addr, .external_trigger_inputs, .queue1_trigger,
    .queue2_trigger, .external_channel_expansion, .conversion_clock);
  ahcr_bus_master m (.clk, .bus_rdata, .bus_ack, .bus_err, .bus_sel, .bus_wr,
    .bus_supervisor, .bus_idx, .bus_byte_en, .bus_wdata);

  // Free-running 50 MHz clock.
  always #10 clk = ~clk;

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check

  task automatic rdc(input logic s, input logic [2:0] i, input logic [15:0] e,
                     input logic [1:0] er);
    logic [15:0] d;
    logic [1:0]  r;
    m.access(1'h0, s, i, 2'h3, 16'h0000, d, r);
    check("bus_resp", {14'h0000, er}, {14'h0000, r});
    check("bus_rdata", e, d);
  endtask : rdc

  task automatic wrc(input logic s, input logic [2:0] i, input logic [15:0] v,
                     input logic [1:0] er);
    logic [15:0] d;
    logic [1:0]  r;
    m.access(1'h1, s, i, 2'h3, v, d, r);
    check("bus_resp", {14'h0000, er}, {14'h0000, r});
  endtask : wrc

  // Reset values, privilege refusal, unmapped index and reserved bits.
  task automatic t_regs();
    rdc(1'h1, IDX_LEVELS, 16'h0000, OK);
    rdc(1'h1, IDX_SETUP, 16'h0000, OK);
    rdc(1'h1, IDX_DIRS, 16'h0000, OK);
    rdc(1'h0, IDX_LEVELS, 16'h0000, BAD);
    wrc(1'h0, IDX_LEVELS, 16'hFFFF, BAD);
    rdc(1'h1, IDX_LEVELS, 16'h0000, OK);
    rdc(1'h1, 3'h5, 16'h0000, BAD);
    wrc(1'h1, IDX_LEVELS, 16'hFFFF, OK);
    rdc(1'h1, IDX_LEVELS, 16'hFFC0, OK);
    wrc(1'h1, IDX_SETUP, 16'hFFFF, OK);
    rdc(1'h1, IDX_SETUP, 16'h907F, OK);
    wrc(1'h1, IDX_SETUP, 16'h0000, OK);
  endtask : t_regs

  // Queue one at level 10, queue two at level 31, every slot and request mix.
  task automatic t_irq();
    logic [7:0] e;
    wrc(1'h1, IDX_LEVELS, 16'h57C0, OK);
    for (int s = 0; s < 4; s++) begin
      for (int q = 0; q < 4; q++) begin
        @(negedge clk);
        level_slot_select    = s[1:0];
        first_queue_request  = q[0];
        second_queue_request = q[1];
        @(negedge clk);
        e = ((q[0] && s == 1) ? 8'h04 : 8'h00) | ((q[1] && s == 3) ? 8'h80 : 8'h00);
        check("irq_lines", {8'h00, e}, {8'h00, irq_lines});
      end
    end
    first_queue_request  = 1'h0;
    second_queue_request = 1'h0;
    // Both queues share level 10; the two requests merge onto one line.
    wrc(1'h1, IDX_LEVELS, 16'h5280, OK);
    level_slot_select    = 2'h1;
    first_queue_request  = 1'h1;
    second_queue_request = 1'h1;
    @(negedge clk);
    check("irq_lines", 16'h0004, {8'h00, irq_lines});
    first_queue_request  = 1'h0;
    second_queue_request = 1'h0;
  endtask : t_irq

  // Mixed directions; port B high nibble stays input as if used for analog.
  task automatic t_ports();
    port_a_pins_in = 8'h5A;
    port_b_pins_in = 8'hC3;
    wrc(1'h1, IDX_DIRS, 16'hF00F, OK);
    wrc(1'h1, IDX_PORTS, 16'hA53C, OK);
    rdc(1'h1, IDX_PORTS, 16'hAACC, OK);
    check("pins_oe", 16'hF00F, {port_a_pins_oe, port_b_pins_oe});
    check("pins_out", 16'hA00C, {port_a_pins_out & 8'hF0, port_b_pins_out & 8'h0F});
  endtask : t_ports

  // Expansion forces port A bits 2..0 out and reads them from the latch.
  task automatic t_expand();
    channel_select_addr = 3'h5;
    wrc(1'h1, IDX_SETUP, 16'h8000, OK);
    repeat (2) @(negedge clk);
    check("expansion", 16'h0001, {15'h0000, external_channel_expansion});
    check("port_a_oe", 16'h00F7, {8'h00, port_a_pins_oe});
    check("port_a_out", 16'h0005, {13'h0000, port_a_pins_out[2:0]});
    rdc(1'h1, IDX_PORTS, 16'hADCC, OK);
    wrc(1'h1, IDX_SETUP, 16'h0000, OK);
    repeat (2) @(negedge clk);
    check("port_a_oe", 16'h00F0, {8'h00, port_a_pins_oe});
  endtask : t_expand

  // Trigger routing straight and swapped, for all pin combinations.
  task automatic t_trig();
    logic [1:0] e;
    for (int w = 0; w < 2; w++) begin
      wrc(1'h1, IDX_SETUP, w[0] ? 16'h1000 : 16'h0000, OK);
      for (int t = 0; t < 4; t++) begin
        external_trigger_inputs = t[1:0];
        @(negedge clk);
        e = w[0] ? {t[0], t[1]} : t[1:0];
        check("triggers", {14'h0000, e}, {14'h0000, queue2_trigger, queue1_trigger});
      end
    end
  endtask : t_trig

  // Period of the conversion clock for boundary and middle codes. Two pulses
  // are skipped first, since a new code only applies from the next period.
  task automatic t_clock();
    logic [6:0] codes [6] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h05, 7'h7F};
    int n;
    foreach (codes[k]) begin
      wrc(1'h1, IDX_SETUP, {9'h000, codes[k]}, OK);
      for (int p = 0; p < 3; p++) begin
        n = 0;
        do begin
          @(negedge clk);
          n++;
        end while (!conversion_clock && n < 300);
      end
      check("clock_period", (codes[k] < 2) ? 16'h0002 : codes[k] + 16'h0001, n[15:0]);
    end
  endtask : t_clock

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  // Watchdog sized well above the roughly four hundred cycles of the run.
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    print_verdict();
  end

  // Main sequence.
  initial begin
    clk = 1'h0;
    arst_n = 1'h0;
    first_queue_request = 1'h0;
    second_queue_request = 1'h0;
    level_slot_select = 2'h0;
    port_a_pins_in = 8'h00;
    port_b_pins_in = 8'h00;
    channel_select_addr = 3'h0;
    external_trigger_inputs = 2'h0;
    repeat (6) @(negedge clk);
    arst_n = 1'h1;
    repeat (4) @(negedge clk);
    t_regs();
    t_irq();
    t_ports();
    t_expand();
    t_trig();
    t_clock();
    print_verdict();
  end
endmodule : ahcr_top_test
